// [cmd_pkg.sv]
// Package: opcodes, field codes, status codes and carrier types of the command block
package cmd_pkg;
    // Opcodes
    localparam logic [7:0] OP_STOP = 8'h1c;
    localparam logic [7:0] OP_XARITH = 8'h21;
    localparam logic [7:0] OP_AXIS = 8'h22;
    localparam logic [7:0] OP_GLOBAL = 8'h23;
    localparam logic [7:0] OP_CLRFLAG = 8'h24;
    // Arithmetic type codes
    localparam logic [7:0] AR_ADD = 8'h00;
    localparam logic [7:0] AR_SUB = 8'h01;
    localparam logic [7:0] AR_MUL = 8'h02;
    localparam logic [7:0] AR_DIV = 8'h03;
    localparam logic [7:0] AR_MOD = 8'h04;
    localparam logic [7:0] AR_AND = 8'h05;
    localparam logic [7:0] AR_OR = 8'h06;
    localparam logic [7:0] AR_XOR = 8'h07;
    localparam logic [7:0] AR_NOT = 8'h08;
    localparam logic [7:0] AR_LOAD = 8'h09;
    localparam logic [7:0] AR_SWAP = 8'h0a;
    // Clear-flag type codes and flag bit positions
    localparam logic [7:0] CL_ALL = 8'h00;
    localparam logic [7:0] CL_LAST = 8'h05;
    localparam int FLAG_TIMEOUT = 0;
    localparam int FLAG_ALARM = 1;
    localparam int FLAG_DEVIATION = 2;
    localparam int FLAG_POSITION = 3;
    localparam int FLAG_SHUTDOWN = 4;
    localparam int NUM_FLAGS = 5;
    // Global parameter banks allowed
    localparam logic [7:0] BANK_0 = 8'h00;
    localparam logic [7:0] BANK_2 = 8'h02;
    localparam logic [7:0] BANK_3 = 8'h03;
    // Reply status codes
    localparam logic [7:0] ST_OK = 8'h64;
    localparam logic [7:0] ST_BAD_SUM = 8'h01;
    localparam logic [7:0] ST_BAD_CMD = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE = 8'h03;
    localparam logic [7:0] ST_BAD_VALUE = 8'h04;
    // Frame length and reset values
    localparam int FRAME_BYTES = 9;
    localparam logic [31:0] ACCU_RST = 32'h0000_0000;
    localparam logic [31:0] XREG_RST = 32'h0000_0000;

    // Decoded command frame
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] opcode;
        logic [7:0] ctype;
        logic [7:0] bank;
        logic [31:0] value;
    } frame_t;

    // Parameter write request
    typedef struct packed {
        logic is_global;
        logic [7:0] index;
        logic [7:0] bank;
        logic [31:0] data;
    } param_wr_t;

    // Reply to the host
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] opcode;
        logic [31:0] value;
    } reply_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DIVW = 2'b10
    } exec_state_t;
endpackage

// [frame_rx.sv]
// Frame assembler: gathers nine bytes, checks the sum, presents one frame
`timescale 1ns/1ns
module frame_rx
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] byte_i,
    input wire logic byte_vld_i,
    input wire logic frame_abort_i,
    output cmd_pkg::frame_t frame_o,
    output logic frame_vld_o,
    output logic sum_ok_o
);
    logic [3:0] cnt_ff;
    logic [7:0] sum_ff;
    logic [63:0] shift_ff;
    logic [63:0] nxt_shift;
    logic last_byte;

    // =====================================================================
    // Byte gathering
    // =====================================================================
    assign last_byte = byte_vld_i && (cnt_ff == 4'(cmd_pkg::FRAME_BYTES - 1));
    assign nxt_shift = {shift_ff[55:0], byte_i};

    // Byte counter; abort resynchronises to a frame start
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_ff <= 4'h0;
        else if (frame_abort_i || last_byte)
            cnt_ff <= 4'h0;
        else if (byte_vld_i)
            cnt_ff <= cnt_ff + 4'h1;
    end

    // Bytes enter MSB first: address, opcode, type, bank, value 3..0
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            shift_ff <= 64'h0;
        else if (byte_vld_i && !last_byte)
            shift_ff <= nxt_shift;
    end

    // Running modulo-256 sum of the eight leading bytes
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            sum_ff <= 8'h00;
        else if (frame_abort_i || last_byte)
            sum_ff <= 8'h00;
        else if (byte_vld_i)
            sum_ff <= sum_ff + byte_i;
    end

    // Frame out, held from flip-flops until the next frame
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            frame_o <= '0;
            frame_vld_o <= 1'b0;
            sum_ok_o <= 1'b0;
        end
        else
        begin
            frame_vld_o <= last_byte && !frame_abort_i;
            if (last_byte)
            begin
                frame_o <= shift_ff;
                sum_ok_o <= (sum_ff == byte_i);
            end
        end
    end
endmodule

// [cmd_exec.sv]
// Command interpreter for stop, X-register arithmetic, parameter transfer and flag clearing
`timescale 1ns/1ns
module cmd_exec
#(
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter int NUM_MOTORS = 1
)
(
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RST_I,
    // Host byte stream (same clock domain)
    input wire logic [7:0] RX_BYTE_I,
    input wire logic RX_VLD_I,
    input wire logic RX_ABORT_I,
    // Stored program source
    input wire logic PROG_VLD_I,
    input wire cmd_pkg::frame_t PROG_CMD_I,
    output logic PROG_RDY_O,
    // Program state and events
    input wire logic PROG_RUN_I,
    input wire logic WAIT_TIMEOUT_I,
    input wire logic [cmd_pkg::NUM_FLAGS-1:0] FLAG_SET_I,
    input wire logic [31:0] ACCU_LOAD_I,
    input wire logic ACCU_LOAD_VLD_I,
    output logic PROG_HALT_O,
    // Parameter writes
    output cmd_pkg::param_wr_t PARAM_WR_O,
    output logic PARAM_WR_VLD_O,
    // Reply and status
    output cmd_pkg::reply_t REPLY_O,
    output logic REPLY_VLD_O,
    output logic [cmd_pkg::NUM_FLAGS-1:0] FLAGS_O,
    output logic [31:0] ACCU_O,
    output logic [31:0] XREG_O,
    output logic BUSY_O
);
    // The motor compare is one byte wide, so 256 motors would wrap to zero
    if (NUM_MOTORS < 1 || NUM_MOTORS > 255)
    begin : g_bad_motors
        $error("NUM_MOTORS out of range");
    end

    cmd_pkg::frame_t rx_frame;
    logic rx_vld;
    logic rx_sum_ok;
    cmd_pkg::frame_t cmd_ff;
    logic direct_ff;
    cmd_pkg::exec_state_t state_ff;
    logic signed [31:0] accu_ff;
    logic signed [31:0] xreg_ff;
    logic signed [31:0] nxt_accu;
    logic signed [31:0] nxt_xreg;
    logic [7:0] nxt_status;
    logic [cmd_pkg::NUM_FLAGS-1:0] flags_ff;
    logic [cmd_pkg::NUM_FLAGS-1:0] clr_mask;
    logic [cmd_pkg::NUM_FLAGS-1:0] set_mask;
    logic exec_go;
    logic accept_direct;
    logic accept_prog;
    logic [31:0] product;

    // =====================================================================
    // Frame reception
    // =====================================================================
    frame_rx u_rx
    (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .byte_i(RX_BYTE_I),
        .byte_vld_i(RX_VLD_I),
        .frame_abort_i(RX_ABORT_I),
        .frame_o(rx_frame),
        .frame_vld_o(rx_vld),
        .sum_ok_o(rx_sum_ok)
    );

    // Direct frames have priority; program commands wait while busy
    assign accept_direct = rx_vld && (rx_frame.addr == MODULE_ADDR) && (state_ff == cmd_pkg::ST_IDLE);
    assign accept_prog = PROG_VLD_I && !rx_vld && (state_ff == cmd_pkg::ST_IDLE);
    assign PROG_RDY_O = (state_ff == cmd_pkg::ST_IDLE) && !rx_vld;
    assign BUSY_O = (state_ff != cmd_pkg::ST_IDLE);
    assign exec_go = (state_ff == cmd_pkg::ST_EXEC) && (rx_sum_ok || !direct_ff);

    // =====================================================================
    // Command latch and sequencing
    // =====================================================================
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            cmd_ff <= '0;
            direct_ff <= 1'b0;
        end
        else if (accept_direct)
        begin
            cmd_ff <= rx_frame;
            direct_ff <= 1'b1;
        end
        else if (accept_prog)
        begin
            cmd_ff <= PROG_CMD_I;
            direct_ff <= 1'b0;
        end
    end

    // One execute cycle per command; the divider must settle within it
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
            state_ff <= cmd_pkg::ST_IDLE;
        else
        begin
            case (state_ff)
                cmd_pkg::ST_IDLE:
                    if (accept_direct || accept_prog)
                        state_ff <= cmd_pkg::ST_EXEC;
                cmd_pkg::ST_EXEC:
                    state_ff <= cmd_pkg::ST_IDLE;
                default:
                    state_ff <= cmd_pkg::ST_IDLE;
            endcase
        end
    end

    // =====================================================================
    // Arithmetic and status decode
    // =====================================================================
    // Only the low word of the product is kept
    assign product = accu_ff * xreg_ff;

    always_comb
    begin
        nxt_accu = accu_ff;
        nxt_xreg = xreg_ff;
        nxt_status = cmd_pkg::ST_OK;
        clr_mask = '0;
        case (cmd_ff.opcode)
            cmd_pkg::OP_STOP:
                nxt_status = cmd_pkg::ST_OK;
            cmd_pkg::OP_XARITH:
                case (cmd_ff.ctype)
                    cmd_pkg::AR_ADD: nxt_accu = accu_ff + xreg_ff;
                    cmd_pkg::AR_SUB: nxt_accu = accu_ff - xreg_ff;
                    cmd_pkg::AR_MUL: nxt_accu = product[31:0];
                    cmd_pkg::AR_DIV:
                        if (xreg_ff == 32'sh0)
                            nxt_status = cmd_pkg::ST_BAD_VALUE;
                        else
                            nxt_accu = accu_ff / xreg_ff;
                    cmd_pkg::AR_MOD:
                        if (xreg_ff == 32'sh0)
                            nxt_status = cmd_pkg::ST_BAD_VALUE;
                        else
                            nxt_accu = accu_ff % xreg_ff;
                    cmd_pkg::AR_AND: nxt_accu = accu_ff & xreg_ff;
                    cmd_pkg::AR_OR: nxt_accu = accu_ff | xreg_ff;
                    cmd_pkg::AR_XOR: nxt_accu = accu_ff ^ xreg_ff;
                    cmd_pkg::AR_NOT: nxt_xreg = ~xreg_ff;
                    cmd_pkg::AR_LOAD: nxt_xreg = accu_ff;
                    cmd_pkg::AR_SWAP:
                    begin
                        nxt_accu = xreg_ff;
                        nxt_xreg = accu_ff;
                    end
                    default: nxt_status = cmd_pkg::ST_BAD_TYPE;
                endcase
            cmd_pkg::OP_AXIS:
                if (cmd_ff.bank >= 8'(NUM_MOTORS))
                    nxt_status = cmd_pkg::ST_BAD_VALUE;
            cmd_pkg::OP_GLOBAL:
                if (!(cmd_ff.bank == cmd_pkg::BANK_0 || cmd_ff.bank == cmd_pkg::BANK_2
                      || cmd_ff.bank == cmd_pkg::BANK_3))
                    nxt_status = cmd_pkg::ST_BAD_VALUE;
            cmd_pkg::OP_CLRFLAG:
                if (cmd_ff.ctype == cmd_pkg::CL_ALL)
                    clr_mask = '1;
                else if (cmd_ff.ctype <= cmd_pkg::CL_LAST)
                    clr_mask[cmd_ff.ctype[2:0] - 3'h1] = 1'b1;
                else
                    nxt_status = cmd_pkg::ST_BAD_TYPE;
            default:
                nxt_status = cmd_pkg::ST_BAD_CMD;
        endcase
    end

    // =====================================================================
    // Accumulator and X register
    // =====================================================================
    // Outside loads (parameter reads) apply only while no command executes
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            accu_ff <= cmd_pkg::ACCU_RST;
            xreg_ff <= cmd_pkg::XREG_RST;
        end
        else if (exec_go)
        begin
            accu_ff <= nxt_accu;
            xreg_ff <= nxt_xreg;
        end
        else if (ACCU_LOAD_VLD_I)
            accu_ff <= ACCU_LOAD_I;
    end

    // =====================================================================
    // Error flags: a set in the clearing cycle wins
    // =====================================================================
    always_comb
    begin
        set_mask = FLAG_SET_I;
        set_mask[cmd_pkg::FLAG_TIMEOUT] = FLAG_SET_I[cmd_pkg::FLAG_TIMEOUT] | WAIT_TIMEOUT_I;
    end

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
            flags_ff <= '0;
        else
            flags_ff <= (flags_ff & ~(exec_go ? clr_mask : '0)) | set_mask;
    end

    // =====================================================================
    // Outputs: halt, parameter write, reply
    // =====================================================================
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            PROG_HALT_O <= 1'b0;
            PARAM_WR_O <= '0;
            PARAM_WR_VLD_O <= 1'b0;
        end
        else
        begin
            PROG_HALT_O <= exec_go && (cmd_ff.opcode == cmd_pkg::OP_STOP) && PROG_RUN_I;
            PARAM_WR_VLD_O <= exec_go && (nxt_status == cmd_pkg::ST_OK)
                              && (cmd_ff.opcode == cmd_pkg::OP_AXIS || cmd_ff.opcode == cmd_pkg::OP_GLOBAL);
            if (exec_go)
            begin
                PARAM_WR_O.is_global <= (cmd_ff.opcode == cmd_pkg::OP_GLOBAL);
                PARAM_WR_O.index <= cmd_ff.ctype;
                PARAM_WR_O.bank <= cmd_ff.bank;
                PARAM_WR_O.data <= accu_ff;
            end
        end
    end

    // Replies go only to direct frames; a bad sum answers without executing
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            REPLY_O <= '0;
            REPLY_VLD_O <= 1'b0;
        end
        else
        begin
            REPLY_VLD_O <= (state_ff == cmd_pkg::ST_EXEC) && direct_ff;
            if ((state_ff == cmd_pkg::ST_EXEC) && direct_ff)
            begin
                REPLY_O.status <= rx_sum_ok ? nxt_status : cmd_pkg::ST_BAD_SUM;
                REPLY_O.opcode <= cmd_ff.opcode;
                REPLY_O.value <= 32'h0000_0000;
            end
        end
    end

    assign FLAGS_O = flags_ff;
    assign ACCU_O = accu_ff;
    assign XREG_O = xreg_ff;
endmodule

// [cmd_exec_asserts.sv]
// Port-level checker for the command interpreter, bound to every instance
`timescale 1ns/1ns
module cmd_exec_asserts
(
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RST_I,
    // Watched inputs
    input wire logic PROG_VLD_I,
    input wire cmd_pkg::frame_t PROG_CMD_I,
    input wire logic PROG_RUN_I,
    input wire logic WAIT_TIMEOUT_I,
    input wire logic [cmd_pkg::NUM_FLAGS-1:0] FLAG_SET_I,
    input wire logic ACCU_LOAD_VLD_I,
    // Watched outputs
    input wire logic PROG_RDY_O,
    input wire logic PROG_HALT_O,
    input wire cmd_pkg::param_wr_t PARAM_WR_O,
    input wire logic PARAM_WR_VLD_O,
    input wire logic REPLY_VLD_O,
    input wire logic [cmd_pkg::NUM_FLAGS-1:0] FLAGS_O,
    input wire logic [31:0] ACCU_O,
    input wire logic [31:0] XREG_O
);
    // ====================
    // Program request decode; quiet means no competing accumulator or flag event
    wire take = PROG_VLD_I && PROG_RDY_O;
    wire [7:0] op = PROG_CMD_I.opcode;
    wire [7:0] ty = PROG_CMD_I.ctype;
    wire [7:0] bk = PROG_CMD_I.bank;
    wire quiet = !ACCU_LOAD_VLD_I && FLAG_SET_I == 5'h00 && !WAIT_TIMEOUT_I;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);

    a_reply_one_cycle: assert property (REPLY_VLD_O |=> !REPLY_VLD_O)
        else $error("reply pulse longer than one cycle");
    a_halt_on_stop: assert property (take && op == cmd_pkg::OP_STOP && PROG_RUN_I |-> ##2 PROG_HALT_O)
        else $error("stop did not halt the program");
    a_halt_needs_run: assert property (PROG_HALT_O |-> $past(PROG_RUN_I))
        else $error("halt without a running program");
    a_load_copies: assert property (take && op == cmd_pkg::OP_XARITH && ty == cmd_pkg::AR_LOAD && quiet
        |-> ##2 XREG_O == $past(ACCU_O, 2) && ACCU_O == $past(ACCU_O, 2))
        else $error("load did not copy accumulator");
    a_axis_write: assert property (take && op == cmd_pkg::OP_AXIS && bk == 8'h00 && quiet
        |-> ##2 PARAM_WR_VLD_O && !PARAM_WR_O.is_global && PARAM_WR_O.index == $past(ty, 2)
        && PARAM_WR_O.data == $past(ACCU_O, 2))
        else $error("axis write wrong");
    a_global_write: assert property (take && op == cmd_pkg::OP_GLOBAL
        && (bk == 8'h00 || bk == 8'h02 || bk == 8'h03)
        |-> ##2 PARAM_WR_VLD_O && PARAM_WR_O.is_global && PARAM_WR_O.bank == $past(bk, 2))
        else $error("global write wrong");
    a_bad_bank_quiet: assert property (take && op == cmd_pkg::OP_GLOBAL && bk == 8'h01 |-> ##2 !PARAM_WR_VLD_O)
        else $error("write to a bank that is not allowed");
    a_clear_all: assert property (take && op == cmd_pkg::OP_CLRFLAG && ty == cmd_pkg::CL_ALL && quiet
        ##1 quiet |-> ##1 FLAGS_O == 5'h00)
        else $error("clear all left a flag set");
    a_timeout_sets: assert property (WAIT_TIMEOUT_I |=> FLAGS_O[cmd_pkg::FLAG_TIMEOUT])
        else $error("timeout flag not set");

    // Main scenarios reached
    c_stop: cover property (take && op == cmd_pkg::OP_STOP);
    c_reply: cover property (REPLY_VLD_O);
    c_global: cover property (PARAM_WR_VLD_O && PARAM_WR_O.is_global);
endmodule

bind cmd_exec cmd_exec_asserts u_chk (.MCLK_I, .RST_I, .PROG_VLD_I, .PROG_CMD_I, .PROG_RUN_I, .WAIT_TIMEOUT_I,
    .FLAG_SET_I, .ACCU_LOAD_VLD_I, .PROG_RDY_O, .PROG_HALT_O, .PARAM_WR_O, .PARAM_WR_VLD_O, .REPLY_VLD_O,
    .FLAGS_O, .ACCU_O, .XREG_O);

// [host_model.sv]
// Host model that sends nine-byte command frames over the byte stream
`timescale 1ns/1ns
module host_model
(
    // Clock
    input wire logic clk_i,
    // Byte stream towards the device
    output logic [7:0] byte_o,
    output logic vld_o
);
    // ====================
    // Frame sender; a released data line shows the inverse of its last byte
    initial
    begin
        byte_o = 8'h00;
        vld_o = 1'b0;
    end

    task automatic send(input cmd_pkg::frame_t f, input logic bad);
        logic [7:0] b [9];
        logic [7:0] s;
        b = '{f.addr, f.opcode, f.ctype, f.bank, f.value[31:24], f.value[23:16], f.value[15:8], f.value[7:0], 8'h00};
        s = 8'h00;
        for (int i = 0; i < 8; i++) s += b[i];
        b[8] = bad ? ~s : s;
        foreach (b[i])
        begin
            @(posedge clk_i);
            byte_o <= b[i];
            vld_o <= 1'b1;
        end
        @(posedge clk_i);
        vld_o <= 1'b0;
        byte_o <= ~b[8];
    endtask
endmodule

// [cmd_exec_bench.sv]
// Self-checking bench for the command interpreter
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module cmd_exec_bench;
    // ====================
    // Stimulus, observed outputs and counters
    logic mclk = 0, rst = 1, prun = 0, pvld = 0, lvld = 0, wto = 0, got = 0, rxv, prdy, halt, pwv, rv, busy;
    logic [4:0] fset = 5'h00, flags;
    logic [31:0] lval = 32'h0, accu, xreg;
    logic [7:0] rxb;
    cmd_pkg::frame_t pcmd = '0;
    cmd_pkg::param_wr_t pwr;
    cmd_pkg::reply_t rep;
    int fail_count = 0, checks_done = 0;

    always #10 mclk = ~mclk;

    host_model u_host (.clk_i(mclk), .byte_o(rxb), .vld_o(rxv));

    // Frame abort is tied off; the bench never cuts a frame short
    cmd_exec u_dut (.MCLK_I(mclk), .RST_I(rst), .RX_BYTE_I(rxb), .RX_VLD_I(rxv), .RX_ABORT_I(1'b0),
        .PROG_VLD_I(pvld), .PROG_CMD_I(pcmd), .PROG_RDY_O(prdy), .PROG_RUN_I(prun), .WAIT_TIMEOUT_I(wto),
        .FLAG_SET_I(fset), .ACCU_LOAD_I(lval), .ACCU_LOAD_VLD_I(lvld), .PROG_HALT_O(halt), .PARAM_WR_O(pwr),
        .PARAM_WR_VLD_O(pwv), .REPLY_O(rep), .REPLY_VLD_O(rv), .FLAGS_O(flags), .ACCU_O(accu), .XREG_O(xreg),
        .BUSY_O(busy));

    // Program command: held until taken, results looked at one edge later
    task automatic prog(input logic [7:0] op, ty, bk);
        @(posedge mclk);
        pcmd <= '{8'h01, op, ty, bk, 32'h0};
        pvld <= 1'b1;
        @(negedge mclk);
        for (int i = 0; i < 8 && prdy !== 1'b1; i++) @(negedge mclk);
        @(posedge mclk);
        pvld <= 1'b0;
        @(negedge mclk);
        `CHK("busy", 1'b1, busy)
        @(posedge mclk);
        #1;
    endtask

    // Direct frame with a junk bank and value; waits a bounded time for the reply
    task automatic dir(input logic [7:0] ad, op, ty, input logic bad);
        u_host.send('{ad, op, ty, 8'h05, 32'h5a5a_0000}, bad);
        got = 0;
        repeat (6)
        begin
            @(posedge mclk);
            #1;
            if (rv === 1'b1)
            begin
                got = 1;
                break;
            end
        end
    endtask

    task automatic ld(input logic [31:0] v);
        @(posedge mclk);
        lval <= v;
        lvld <= 1'b1;
        @(posedge mclk);
        lvld <= 1'b0;
        #1;
    endtask

    task automatic fl(input logic [4:0] v);
        @(posedge mclk);
        fset <= v;
        @(posedge mclk);
        fset <= 5'h00;
        #1;
    endtask

    // X is loaded from the accumulator, since no other way in exists
    task automatic setx(input logic [31:0] a, b);
        ld(b);
        prog(cmd_pkg::OP_XARITH, cmd_pkg::AR_LOAD, 8'h00);
        ld(a);
    endtask

    task automatic t_arith();
        logic signed [31:0] a, b, e;
        a = -32'sd100;
        b = 32'sd7;
        for (int t = 0; t <= 10; t++)
        begin
            setx(a, b);
            dir(8'h01, cmd_pkg::OP_XARITH, t[7:0], 1'b0);
            case (t)
                0: e = a + b;
                1: e = a - b;
                2: e = a * b;
                3: e = a / b;
                4: e = a % b;
                5: e = a & b;
                6: e = a | b;
                7: e = a ^ b;
                8: e = a;
                default: e = (t == 9) ? a : b;
            endcase
            `CHK("reply", {1'b1, cmd_pkg::ST_OK}, {got, rep.status})
            `CHK("accu", e, accu)
            if (t == 8) `CHK("inverted", ~b, xreg)
            if (t >= 9) `CHK("xreg", a, xreg)
        end
    endtask

    task automatic t_param();
        logic [7:0] bk [4];
        bk = '{8'h00, 8'h02, 8'h03, 8'h01};
        ld(32'h1234_5678);
        prog(cmd_pkg::OP_AXIS, 8'h04, 8'h00);
        `CHK("axis", {1'b1, 1'b0, 8'h04, 8'h00, 32'h1234_5678}, {pwv, pwr})
        foreach (bk[i])
        begin
            prog(cmd_pkg::OP_GLOBAL, 8'h2a, bk[i]);
            `CHK("glob vld", i < 3, pwv)
            if (i < 3) `CHK("glob wr", {1'b1, 8'h2a, bk[i], 32'h1234_5678}, pwr)
        end
    endtask

    task automatic t_flags();
        fl(5'h1f);
        for (int t = 1; t <= 5; t++)
        begin
            dir(8'h01, cmd_pkg::OP_CLRFLAG, t[7:0], 1'b0);
            `CHK("flags one", 5'h1f & (5'h1f << t), flags)
        end
        fl(5'h1f);
        dir(8'h01, cmd_pkg::OP_CLRFLAG, cmd_pkg::CL_ALL, 1'b0);
        `CHK("flags all", 5'h00, flags)
        @(posedge mclk);
        wto <= 1'b1;
        @(posedge mclk);
        wto <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        `CHK("timeout", 5'h01, flags)
        prog(cmd_pkg::OP_CLRFLAG, cmd_pkg::CL_ALL, 8'h00);
        `CHK("prog clear", 5'h00, flags)
    endtask

    task automatic t_stop();
        @(posedge mclk);
        prun <= 1'b1;
        prog(cmd_pkg::OP_STOP, 8'h07, 8'h09);
        `CHK("halt", 1'b1, halt)
        @(posedge mclk);
        prun <= 1'b0;
        prog(cmd_pkg::OP_STOP, 8'h00, 8'h00);
        `CHK("no halt", 1'b0, halt)
        dir(8'h01, cmd_pkg::OP_STOP, 8'h00, 1'b0);
        `CHK("stop reply", {1'b1, cmd_pkg::ST_OK, cmd_pkg::OP_STOP, 32'h0}, {got, rep})
    endtask

    // Refusals must leave the accumulator alone
    task automatic t_err();
        ld(32'h0000_0011);
        dir(8'h01, cmd_pkg::OP_XARITH, cmd_pkg::AR_ADD, 1'b1);
        `CHK("bad sum", {cmd_pkg::ST_BAD_SUM, 32'h11}, {rep.status, accu})
        dir(8'h02, cmd_pkg::OP_XARITH, cmd_pkg::AR_ADD, 1'b0);
        `CHK("other addr", 1'b0, got)
        dir(8'h01, 8'h7f, 8'h00, 1'b0);
        `CHK("bad op", cmd_pkg::ST_BAD_CMD, rep.status)
        dir(8'h01, cmd_pkg::OP_XARITH, 8'h0b, 1'b0);
        `CHK("bad type", cmd_pkg::ST_BAD_TYPE, rep.status)
        setx(32'h11, 32'h0);
        dir(8'h01, cmd_pkg::OP_XARITH, cmd_pkg::AR_DIV, 1'b0);
        `CHK("div zero", {cmd_pkg::ST_BAD_VALUE, 32'h11}, {rep.status, accu})
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        `CHK("rst state", {1'b1, 64'h0, 5'h00}, {prdy, accu, xreg, flags})
        t_arith();
        t_param();
        t_flags();
        t_stop();
        t_err();
        end_of_test();
    end

    // Watchdog well beyond the roughly 420 cycles the tests take
    initial
    begin
        #400000;
        fail_count++;
        end_of_test();
    end
endmodule
